// ---- lpc_pkg.sv ----
// shared constants, types and register layout of the line pixel correction path
// assumes one 200 MHz clock and an 8-bit pixel stream from the sensor side
package lpc_pkg;

    // ------------------------------------------------------------------
    // widths and counts
    // ------------------------------------------------------------------
    localparam int PIX_W          = 8;
    localparam int COEF_W         = 12;
    localparam int COEF_FRAC      = 8;
    localparam int ACC_LINES_LOG2 = 12;   // 4096 lines accumulated
    localparam int SUM_W          = PIX_W + ACC_LINES_LOG2;
    localparam int SLOT_COUNT     = 5;
    localparam int LINE_W_DEF     = 2048;
    localparam int ADDR_W         = 8;
    localparam int CLK_MHZ        = 200;

    // ------------------------------------------------------------------
    // register offsets
    // ------------------------------------------------------------------
    localparam logic [ADDR_W-1:0] REG_CTRL   = 8'h00;
    localparam logic [ADDR_W-1:0] REG_TARGET = 8'h04;
    localparam logic [ADDR_W-1:0] REG_SLOT   = 8'h08;
    localparam logic [ADDR_W-1:0] REG_CMD    = 8'h0C;
    localparam logic [ADDR_W-1:0] REG_STATUS = 8'h10;
    localparam logic [ADDR_W-1:0] REG_LINES  = 8'h14;

    // ------------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------------
    localparam int CTRL_GAIN_BIT   = 0;
    localparam int CTRL_DARK_BIT   = 1;
    localparam int CTRL_MIRROR_BIT = 2;
    localparam int CTRL_AUTO_BIT   = 3;
    localparam int CTRL_PAT_LSB    = 4;
    localparam int CMD_GEN_BIT     = 0;
    localparam int CMD_STORE_BIT   = 1;
    localparam int CMD_RESTORE_BIT = 2;
    localparam int STAT_BUSY_BIT   = 0;
    localparam int STAT_VALID_BIT  = 1;
    localparam int STAT_REFUSE_BIT = 2;
    localparam int STAT_TGT_LSB    = 8;

    // ------------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------------
    localparam logic [5:0] CTRL_RESET   = 6'h0B;  // gain on, dark on, auto, no pattern
    localparam logic [7:0] TARGET_RESET = 8'h80;
    localparam logic [2:0] SLOT_RESET   = 3'h0;

    // ------------------------------------------------------------------
    // types
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        PAT_OFF                     = 2'h0,
        PAT_RAMP_HORIZONTAL         = 2'h1,
        PAT_RAMP_DIAGONAL           = 2'h2,
        PAT_RAMP_DIAGONAL_SCROLLING = 2'h3
    } lpc_pat_t;

    typedef enum logic [2:0] {
        ST_IDLE    = 3'h0,
        ST_ACC     = 3'h1,
        ST_FIN     = 3'h3,
        ST_STORE   = 3'h2,
        ST_RESTORE = 3'h6
    } lpc_state_t;

    typedef struct packed {
        logic             sol;
        logic [PIX_W-1:0] data;
    } lpc_pix_t;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [31:0]       wdata;
        logic              wr;
        logic              rd;
    } lpc_bus_t;

endpackage

// ---- lpc_mem.sv ----
// simple dual port memory with registered read data, new data on a same-address clash
// assumes one clock; array contents are undefined after reset
`timescale 1ns/1ps
module lpc_mem #(
    parameter int DW = 8,
    parameter int DEPTH = 16,
    parameter int AW = 4
) (
    input  wire logic          ref_clk,
    input  wire logic          nrst,
    input  wire logic          wr_en,
    input  wire logic [AW-1:0] wr_addr,
    input  wire logic [DW-1:0] wr_data,
    input  wire logic [AW-1:0] rd_addr,
    output logic      [DW-1:0] rd_data_ff
);
    logic [DW-1:0] mem [DEPTH];

    // write port
    always_ff @(posedge ref_clk) begin
        if (wr_en) begin
            mem[wr_addr] <= wr_data;
        end
    end

    // read port, one cycle latency; a write to the read address passes through
    // so a mirrored read of the last column never returns the stale line
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            rd_data_ff <= '0;
        end else if (wr_en && (wr_addr == rd_addr)) begin
            rd_data_ff <= wr_data;
        end else begin
            rd_data_ff <= mem[rd_addr];
        end
    end
endmodule

// ---- lpc_pat.sv ----
// internal grey ramp generator, combinational
// assumes column, row and scroll counters are kept by the caller
`timescale 1ns/1ps
module lpc_pat
    import lpc_pkg::*;
(
    input  lpc_pkg::lpc_pat_t       sel,
    input  wire logic [PIX_W-1:0]   col,
    input  wire logic [PIX_W-1:0]   row,
    input  wire logic [PIX_W-1:0]   scroll,
    output logic      [PIX_W-1:0]   value
);
    // pick ramp by selection; wraps at full scale
    always_comb begin
        case (sel)
            PAT_RAMP_HORIZONTAL:         value = col;
            PAT_RAMP_DIAGONAL:           value = PIX_W'(col + row);
            PAT_RAMP_DIAGONAL_SCROLLING: value = PIX_W'(col + row + scroll);
            default:                     value = '0;
        endcase
    end
endmodule

// ---- lpc_path.sv ----
// line pixel path: gain coefficient generation, slot store/restore,
// gain apply, test pattern and horizontal mirror
// assumes full-width lines of LINE_W pixels (power of two), pixels
// flagged by pix_in_valid with sol on the first; output is one line late
`timescale 1ns/1ps
module lpc_path #(
    parameter int LINE_W = lpc_pkg::LINE_W_DEF,
    parameter int ACC_LOG2 = lpc_pkg::ACC_LINES_LOG2
) (
    input  wire logic              ref_clk,
    input  wire logic              nrst,
    input  lpc_pkg::lpc_bus_t      bus,
    output logic [31:0]            rdata_ff,
    input  wire logic              pix_in_valid,
    input  lpc_pkg::lpc_pix_t      pix_in,
    output logic                   pix_out_valid_ff,
    output lpc_pkg::lpc_pix_t      pix_out,
    output logic                   dark_offset_correction_en
);
    import lpc_pkg::*;

    // ------------------------------------------------------------------
    // constants and helpers
    // ------------------------------------------------------------------
    localparam int CW = $clog2(LINE_W);
    localparam int SW = $clog2(SLOT_COUNT * LINE_W);
    localparam logic [CW-1:0] COL_LAST = CW'(LINE_W - 1);
    localparam logic [ACC_LOG2:0] LINES_NEED = (ACC_LOG2+1)'(1) << ACC_LOG2;
    localparam logic [COEF_W-1:0] COEF_MAX = '1;

    // target over average in fixed point, saturated
    function automatic logic [COEF_W-1:0] calc_coef(input logic [PIX_W-1:0] tgt,
                                                    input logic [PIX_W-1:0] avg);
        logic [15:0] q;
        q = 16'h0000;
        if (avg == '0) begin
            return COEF_MAX;
        end
        q = {tgt, 8'h00} / {8'h00, avg};
        return (q > 16'(COEF_MAX)) ? COEF_MAX : q[COEF_W-1:0];
    endfunction

    // pixel times coefficient, clipped to full scale
    function automatic logic [PIX_W-1:0] apply_gain(input logic [PIX_W-1:0] p,
                                                    input logic [COEF_W-1:0] c);
        logic [PIX_W+COEF_W-1:0] prod;
        prod = p * c;
        prod = prod >> COEF_FRAC;
        return (prod > (PIX_W+COEF_W)'(8'hFF)) ? 8'hFF : prod[PIX_W-1:0];
    endfunction

    function automatic logic [SW-1:0] slot_addr(input logic [2:0] s, input logic [CW-1:0] a);
        return SW'(s * LINE_W) + SW'(a);
    endfunction

    // ------------------------------------------------------------------
    // register file
    // ------------------------------------------------------------------
    logic [5:0]        ctrl_ff, nxt_ctrl;
    logic [7:0]        tgt_reg_ff, nxt_tgt_reg;
    logic [2:0]        slot_sel_ff, nxt_slot_sel;
    logic              refused_ff, nxt_refused;
    logic [31:0]       nxt_rdata;
    logic              cmd_gen, cmd_store, cmd_restore, cmd_refused;
    lpc_state_t        state_ff, nxt_state;
    logic              coef_ok_ff, nxt_coef_ok;
    logic [7:0]        tgt_ff, nxt_tgt;
    logic [ACC_LOG2:0] lines_ff, nxt_lines;

    wire logic gain_correction_enable = ctrl_ff[CTRL_GAIN_BIT];
    wire logic mirror_en             = ctrl_ff[CTRL_MIRROR_BIT];
    wire logic target_level_auto_a   = ctrl_ff[CTRL_AUTO_BIT];
    wire lpc_pat_t pattern_select    = lpc_pat_t'(ctrl_ff[CTRL_PAT_LSB +: 2]);
    assign dark_offset_correction_en = ctrl_ff[CTRL_DARK_BIT];

    wire logic cmd_wr = bus.wr && (bus.addr == REG_CMD);
    assign cmd_gen     = cmd_wr && bus.wdata[CMD_GEN_BIT];
    assign cmd_store   = cmd_wr && bus.wdata[CMD_STORE_BIT];
    assign cmd_restore = cmd_wr && bus.wdata[CMD_RESTORE_BIT];
    // busy or out-of-range slot turns a command away
    assign cmd_refused = cmd_wr && (bus.wdata[2:0] != 3'h0) && ((state_ff != ST_IDLE) ||
                         ((cmd_store || cmd_restore) && (slot_sel_ff >= 3'(SLOT_COUNT))));

    // register writes and read mux
    always_comb begin
        nxt_ctrl     = ctrl_ff;
        nxt_tgt_reg  = tgt_reg_ff;
        nxt_slot_sel = slot_sel_ff;
        nxt_refused  = refused_ff;
        nxt_rdata    = 32'h0000_0000;
        if (bus.wr) begin
            case (bus.addr)
                REG_CTRL:   nxt_ctrl = bus.wdata[5:0];
                REG_TARGET: nxt_tgt_reg = bus.wdata[7:0];
                REG_SLOT:   nxt_slot_sel = bus.wdata[2:0];
                REG_STATUS: nxt_refused = refused_ff & ~bus.wdata[STAT_REFUSE_BIT];
                default:    nxt_ctrl = ctrl_ff;
            endcase
        end
        if (cmd_refused) begin
            nxt_refused = 1'b1;                                 // set beats clear
        end
        if (bus.rd) begin
            case (bus.addr)
                REG_CTRL:   nxt_rdata = {26'h0, ctrl_ff};
                REG_TARGET: nxt_rdata = {24'h0, tgt_reg_ff};
                REG_SLOT:   nxt_rdata = {29'h0, slot_sel_ff};
                REG_STATUS: nxt_rdata = {16'h0, tgt_ff, 5'h0, refused_ff, coef_ok_ff,
                                         state_ff != ST_IDLE};
                REG_LINES:  nxt_rdata = 32'(lines_ff);
                default:    nxt_rdata = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            ctrl_ff     <= CTRL_RESET;
            tgt_reg_ff  <= TARGET_RESET;
            slot_sel_ff <= SLOT_RESET;
            refused_ff  <= 1'b0;
            rdata_ff    <= 32'h0000_0000;
        end else begin
            ctrl_ff     <= nxt_ctrl;
            tgt_reg_ff  <= nxt_tgt_reg;
            slot_sel_ff <= nxt_slot_sel;
            refused_ff  <= nxt_refused;
            rdata_ff    <= nxt_rdata;
        end
    end

    // ------------------------------------------------------------------
    // input stage: column and line counters, pattern source
    // ------------------------------------------------------------------
    logic [CW-1:0]    col_ff, nxt_col;
    logic [7:0]       row_ff, nxt_row, scroll_ff, nxt_scroll;
    logic             wbank_ff, nxt_wbank, have_ff, nxt_have;
    logic [PIX_W-1:0] pat_val, src;
    logic [CW-1:0]    cur_col;
    logic             last_pix;

    assign cur_col  = pix_in.sol ? '0 : col_ff;
    assign last_pix = pix_in_valid && (cur_col == COL_LAST);

    lpc_pat u_pat (
        .sel    (pattern_select),
        .col    (PIX_W'(cur_col)),
        .row    (row_ff),
        .scroll (scroll_ff),
        .value  (pat_val)
    );

    // test pattern takes the place of sensor data
    assign src = (pattern_select == PAT_OFF) ? pix_in.data : pat_val;

    // counters advance per pixel and per line
    always_comb begin
        nxt_col    = col_ff;
        nxt_row    = row_ff;
        nxt_scroll = scroll_ff;
        nxt_wbank  = wbank_ff;
        nxt_have   = have_ff;
        if (pix_in_valid) begin
            nxt_col = CW'(cur_col + 1'b1);
        end
        if (last_pix) begin
            nxt_row    = 8'(row_ff + 1'b1);
            nxt_scroll = 8'(scroll_ff + 1'b1);
            nxt_wbank  = ~wbank_ff;
            nxt_have   = 1'b1;
        end
    end

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            col_ff    <= '0;
            row_ff    <= 8'h00;
            scroll_ff <= 8'h00;
            wbank_ff  <= 1'b0;
            have_ff   <= 1'b0;
        end else begin
            col_ff    <= nxt_col;
            row_ff    <= nxt_row;
            scroll_ff <= nxt_scroll;
            wbank_ff  <= nxt_wbank;
            have_ff   <= nxt_have;
        end
    end

    // ------------------------------------------------------------------
    // generation, store and restore sequencer
    // ------------------------------------------------------------------
    logic          armed_ff, nxt_armed, first_ff, nxt_first;
    logic [7:0]    tmax_ff, nxt_tmax;
    logic [CW-1:0] cp_addr_ff, nxt_cp_addr, cp_wa_ff, nxt_cp_wa;
    logic          cp_wr_ff, nxt_cp_wr, cp_run_ff, nxt_cp_run;
    logic [2:0]    cp_slot_ff, nxt_cp_slot;
    logic          acc_on;

    // accumulate only whole lines, from a start of line onward
    assign acc_on = (state_ff == ST_ACC) && pix_in_valid && (armed_ff || pix_in.sol);

    always_comb begin
        nxt_state   = state_ff;
        nxt_coef_ok = coef_ok_ff;
        nxt_tgt     = tgt_ff;
        nxt_lines   = lines_ff;
        nxt_armed   = armed_ff;
        nxt_first   = first_ff;
        nxt_tmax    = tmax_ff;
        nxt_cp_slot = cp_slot_ff;
        nxt_cp_run  = cp_run_ff;
        nxt_cp_addr = cp_addr_ff;
        nxt_cp_wr   = cp_run_ff;
        nxt_cp_wa   = cp_addr_ff;
        if (cp_run_ff) begin
            nxt_cp_addr = CW'(cp_addr_ff + 1'b1);
            nxt_cp_run  = (cp_addr_ff != COL_LAST);
        end
        case (state_ff)
            ST_IDLE: begin
                if (!cmd_refused && cmd_gen) begin
                    nxt_state = ST_ACC;
                    nxt_lines = '0;
                    nxt_armed = 1'b0;
                    nxt_first = 1'b1;
                    nxt_tmax  = 8'h00;
                end else if (!cmd_refused && (cmd_store || cmd_restore)) begin
                    nxt_state   = cmd_store ? ST_STORE : ST_RESTORE;
                    nxt_cp_slot = slot_sel_ff;
                    nxt_cp_run  = 1'b1;
                    nxt_cp_addr = '0;
                end
            end
            ST_ACC: begin
                if (acc_on) begin
                    nxt_armed = 1'b1;
                    nxt_tmax  = (src > tmax_ff) ? src : tmax_ff;
                end
                if (acc_on && last_pix) begin
                    nxt_first = 1'b0;
                    nxt_lines = (ACC_LOG2+1)'(lines_ff + 1'b1);
                    if (nxt_lines == LINES_NEED) begin
                        nxt_state   = ST_FIN;
                        nxt_tgt     = target_level_auto_a ? tmax_ff : tgt_reg_ff;
                        nxt_cp_run  = 1'b1;
                        nxt_cp_addr = '0;
                    end
                end
            end
            ST_FIN, ST_STORE, ST_RESTORE: begin
                if (cp_wr_ff && (cp_wa_ff == COL_LAST)) begin
                    nxt_state = ST_IDLE;
                    if (state_ff != ST_STORE) begin
                        nxt_coef_ok = 1'b1;
                    end
                end
            end
            default: nxt_state = ST_IDLE;
        endcase
    end

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            state_ff   <= ST_IDLE;
            coef_ok_ff <= 1'b0;
            tgt_ff     <= 8'h00;
            lines_ff   <= '0;
            armed_ff   <= 1'b0;
            first_ff   <= 1'b0;
            tmax_ff    <= 8'h00;
            cp_slot_ff <= 3'h0;
            cp_run_ff  <= 1'b0;
            cp_addr_ff <= '0;
            cp_wr_ff   <= 1'b0;
            cp_wa_ff   <= '0;
        end else begin
            state_ff   <= nxt_state;
            coef_ok_ff <= nxt_coef_ok;
            tgt_ff     <= nxt_tgt;
            lines_ff   <= nxt_lines;
            armed_ff   <= nxt_armed;
            first_ff   <= nxt_first;
            tmax_ff    <= nxt_tmax;
            cp_slot_ff <= nxt_cp_slot;
            cp_run_ff  <= nxt_cp_run;
            cp_addr_ff <= nxt_cp_addr;
            cp_wr_ff   <= nxt_cp_wr;
            cp_wa_ff   <= nxt_cp_wa;
        end
    end

    // ------------------------------------------------------------------
    // memories: sums, active coefficients, slots, line buffer
    // ------------------------------------------------------------------
    logic [SUM_W-1:0]  sum_rd, sum_sh;
    logic [COEF_W-1:0] coef_rd, slot_rd, coef_wd;
    logic [PIX_W-1:0]  lb_rd;
    logic [PIX_W-1:0]  s1_pix_ff, nxt_s1_pix;
    logic [CW-1:0]     s1_col_ff, nxt_s1_col, rd_col;
    logic              s1_valid_ff, s1_bank_ff, s1_acc_ff, s1_first_ff, s1_gain_ff;
    logic              nxt_s1_valid, nxt_s1_bank, nxt_s1_acc, nxt_s1_first, nxt_s1_gain;
    logic              nxt_out_valid, out_sol_ff, nxt_out_sol;

    assign sum_sh  = sum_rd >> ACC_LOG2;
    // coefficient from the averaged response of each pixel
    assign coef_wd = (state_ff == ST_FIN) ? calc_coef(tgt_ff, sum_sh[PIX_W-1:0])
                                          : slot_rd;

    lpc_mem #(.DW(SUM_W), .DEPTH(LINE_W), .AW(CW)) u_sum (
        .ref_clk    (ref_clk),
        .nrst       (nrst),
        .wr_en      (s1_acc_ff),
        .wr_addr    (s1_col_ff),
        .wr_data    (s1_first_ff ? SUM_W'(s1_pix_ff) : SUM_W'(sum_rd + s1_pix_ff)),
        .rd_addr    ((state_ff == ST_FIN) ? cp_addr_ff : cur_col),
        .rd_data_ff (sum_rd)
    );

    lpc_mem #(.DW(COEF_W), .DEPTH(LINE_W), .AW(CW)) u_coef (
        .ref_clk    (ref_clk),
        .nrst       (nrst),
        .wr_en      (cp_wr_ff && (state_ff == ST_FIN || state_ff == ST_RESTORE)),
        .wr_addr    (cp_wa_ff),
        .wr_data    (coef_wd),
        .rd_addr    ((state_ff == ST_STORE) ? cp_addr_ff : cur_col),
        .rd_data_ff (coef_rd)
    );

    lpc_mem #(.DW(COEF_W), .DEPTH(SLOT_COUNT * LINE_W), .AW(SW)) u_slot (
        .ref_clk    (ref_clk),
        .nrst       (nrst),
        .wr_en      (cp_wr_ff && (state_ff == ST_STORE)),
        .wr_addr    (slot_addr(cp_slot_ff, cp_wa_ff)),
        .wr_data    (coef_rd),
        .rd_addr    (slot_addr(cp_slot_ff, cp_addr_ff)),
        .rd_data_ff (slot_rd)
    );

    // mirror reads the previous line back to front
    assign rd_col = mirror_en ? CW'(COL_LAST - cur_col) : cur_col;

    lpc_mem #(.DW(PIX_W), .DEPTH(2 * LINE_W), .AW(CW + 1)) u_line (
        .ref_clk    (ref_clk),
        .nrst       (nrst),
        .wr_en      (s1_valid_ff),
        .wr_addr    ({s1_bank_ff, s1_col_ff}),
        .wr_data    (s1_gain_ff ? apply_gain(s1_pix_ff, coef_rd) : s1_pix_ff),
        .rd_addr    ({~wbank_ff, rd_col}),
        .rd_data_ff (lb_rd)
    );

    // stage one and output flags
    always_comb begin
        nxt_s1_valid  = pix_in_valid;
        nxt_s1_col    = cur_col;
        nxt_s1_pix    = src;
        nxt_s1_bank   = wbank_ff;
        nxt_s1_acc    = acc_on;
        nxt_s1_first  = first_ff;
        // no gain while a store borrows the coefficient port
        nxt_s1_gain   = gain_correction_enable && coef_ok_ff && (state_ff != ST_STORE);
        nxt_out_valid = pix_in_valid && have_ff;
        nxt_out_sol   = pix_in_valid && have_ff && (cur_col == '0);
    end

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            s1_valid_ff      <= 1'b0;
            s1_col_ff        <= '0;
            s1_pix_ff        <= '0;
            s1_bank_ff       <= 1'b0;
            s1_acc_ff        <= 1'b0;
            s1_first_ff      <= 1'b0;
            s1_gain_ff       <= 1'b0;
            pix_out_valid_ff <= 1'b0;
            out_sol_ff       <= 1'b0;
        end else begin
            s1_valid_ff      <= nxt_s1_valid;
            s1_col_ff        <= nxt_s1_col;
            s1_pix_ff        <= nxt_s1_pix;
            s1_bank_ff       <= nxt_s1_bank;
            s1_acc_ff        <= nxt_s1_acc;
            s1_first_ff      <= nxt_s1_first;
            s1_gain_ff       <= nxt_s1_gain;
            pix_out_valid_ff <= nxt_out_valid;
            out_sol_ff       <= nxt_out_sol;
        end
    end

    assign pix_out = '{sol: out_sol_ff, data: lb_rd};
endmodule

// ---- lpc_path_end_marker_unused.sv ----
// spare file; holds no logic

// ---- lpc_sensor.sv ----
// sensor model: gap-free lines of LINE_W pixels, value column xor a5
// assumes the path samples pixels on the rising edge of ref_clk
`timescale 1ns/1ps
module lpc_sensor
    import lpc_pkg::*;
#(parameter int LINE_W = 16) (
    input  wire logic        ref_clk,
    input  wire logic        nrst,
    output logic             pix_in_valid,
    output lpc_pkg::lpc_pix_t pix_in
);
    logic [7:0] col_ff;
    // lines back to back, column wraps at line end
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            col_ff <= 8'h00;
            pix_in_valid <= 1'b0;
            pix_in <= '0;
        end else begin
            pix_in_valid <= 1'b1;
            // raw level a0 to af, inside the advised 100 to 200 band
            pix_in <= '{col_ff == 8'h00, col_ff ^ 8'hA5};
            col_ff <= (col_ff == 8'(LINE_W - 1)) ? 8'h00 : col_ff + 8'h01;
        end
    end
endmodule

// ---- lpc_path_asserts.sv ----
// port checker of lpc_path
// assumes a gap-free pixel stream at the input
`timescale 1ns/1ps
module lpc_path_asserts
    import lpc_pkg::*;
#(parameter int LINE_W = 16, parameter int ACC_LOG2 = 2) (
    input wire logic         ref_clk,
    input wire logic         nrst,
    input lpc_pkg::lpc_bus_t bus,
    input wire logic [31:0]  rdata_ff,
    input wire logic         pix_in_valid,
    input lpc_pkg::lpc_pix_t pix_in,
    input wire logic         pix_out_valid_ff,
    input lpc_pkg::lpc_pix_t pix_out,
    input wire logic         dark_offset_correction_en
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!nrst);
    wire ctl_w = bus.wr && bus.addr == REG_CTRL;
    wire sol_o = pix_out_valid_ff && pix_out.sol;
    wire dk = dark_offset_correction_en;
    // control enable bit, write and readback
    dark_write_a: assert property (ctl_w |=> dk == $past(bus.wdata[1]))
        else $error("dark enable missed write");
    dark_hold_a: assert property (!ctl_w |=> $stable(dk))
        else $error("dark enable moved");
    dark_read_a: assert property (bus.rd && bus.addr == REG_CTRL
        |=> rdata_ff[1] == $past(dk)) else $error("control readback wrong");
    // target fields stay 8 bits wide
    target_range_a: assert property (bus.rd && bus.addr == REG_TARGET
        |=> rdata_ff[31:8] == 24'h00_0000) else $error("target too wide");
    status_tgt_a: assert property (bus.rd && bus.addr == REG_STATUS
        |=> rdata_ff[31:16] == 16'h0000) else $error("target used too wide");
    // output line timing
    out_follow_a: assert property (pix_out_valid_ff |-> $past(pix_in_valid))
        else $error("output without input");
    sol_follow_a: assert property (sol_o |-> $past(pix_in_valid && pix_in.sol))
        else $error("line start misplaced");
    sol_gap_a: assert property (sol_o |=> (!pix_out.sol)[*8])
        else $error("line too short");
    cover property (bus.wr && bus.addr == REG_CMD);
    cover property (ctl_w && bus.wdata[CTRL_MIRROR_BIT]);
    cover property (sol_o);
endmodule
bind lpc_path lpc_path_asserts #(.LINE_W(LINE_W), .ACC_LOG2(ACC_LOG2)) u_chk (
    .ref_clk(ref_clk), .nrst(nrst), .bus(bus), .rdata_ff(rdata_ff),
    .pix_in_valid(pix_in_valid), .pix_in(pix_in), .pix_out_valid_ff(pix_out_valid_ff),
    .pix_out(pix_out), .dark_offset_correction_en(dark_offset_correction_en));

// ---- tb.sv ----
// self-checking bench of lpc_path with the sensor model
// assumes 16-pixel lines and 4 accumulated lines to keep the run short
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin n_compared++; if ((got) !== (ex)) begin n_errors++; \
    $display("wrong value %s exp %h got %h", nm, ex, got); end end
module tb;
    import lpc_pkg::*;
    localparam int LW = 16;
    logic ref_clk = 1'b0;
    logic nrst = 1'b0;
    lpc_bus_t bus = '0;
    logic [31:0] rdata_ff, v;
    logic pv, ov, dk;
    lpc_pix_t pi, po;
    int n_errors = 0;
    int n_compared = 0;
    lpc_sensor #(.LINE_W(LW)) u_sen (.ref_clk(ref_clk), .nrst(nrst), .pix_in_valid(pv),
        .pix_in(pi));
    lpc_path #(.LINE_W(LW), .ACC_LOG2(2)) dut (.ref_clk(ref_clk), .nrst(nrst), .bus(bus),
        .rdata_ff(rdata_ff), .pix_in_valid(pv), .pix_in(pi), .pix_out_valid_ff(ov),
        .pix_out(po), .dark_offset_correction_en(dk));
    initial forever #2.5 ref_clk = ~ref_clk;
    // one-cycle bus strobes, read data taken in the cycle after
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk) bus <= '{a, d, 1'b1, 1'b0};
        @(posedge ref_clk) bus.wr <= 1'b0;
        #1;
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge ref_clk) bus <= '{a, 32'h0, 1'b0, 1'b1};
        @(posedge ref_clk) bus.rd <= 1'b0;
        #1 v = rdata_ff;
    endtask
    // expected pixel k: raw sensor, ramp, or ramp times gain of target tgt
    function automatic logic [7:0] ex(int k, bit pat, bit mir, int tgt);
        int c, cf;
        c = mir ? LW - 1 - k : k;
        if (!pat) return 8'(c) ^ 8'hA5;
        if (tgt < 0) return 8'(c);
        cf = (c == 0 || tgt * 256 / c > 4095) ? 4095 : tgt * 256 / c;
        return ((c * cf) >> 8) > 255 ? 8'hFF : 8'((c * cf) >> 8);
    endfunction
    // skip to the second line start seen, then check one whole line
    task automatic line(input bit pat, input bit mir, input int tgt);
        int n;
        n = 0;
        for (int i = 0; i < 200 && n < 2; i++) begin
            @(posedge ref_clk) #1;
            if (ov === 1'b1 && po.sol === 1'b1) n++;
        end
        if (n < 2) n_errors++;
        for (int k = 0; k < LW; k++) begin
            `CHK("pixel", ex(k, pat, mir, tgt), po.data)
            @(posedge ref_clk) #1;
        end
        $display("line checked, errors %0d", n_errors);
    endtask
    task automatic cmd(input logic [31:0] c);
        wr(REG_CMD, c);
        v = 32'h1;
        for (int i = 0; i < 400 && v[STAT_BUSY_BIT] !== 1'b0; i++) rd(REG_STATUS);
        if (v[STAT_BUSY_BIT] !== 1'b0) n_errors++;
    endtask
    task automatic finish_test();
        $display("compared %0d mismatches %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    initial begin
        #100000;
        n_errors++;
        finish_test();
    end
    initial begin
        repeat (10) @(posedge ref_clk);
        nrst <= 1'b1;
        rd(REG_CTRL);
        `CHK("ctrl", 32'h0000_000B, v)
        rd(REG_TARGET);
        `CHK("target", 32'h0000_0080, v)
        rd(8'h40);
        `CHK("unmapped", 32'h0000_0000, v)
        line(0, 0, -1);
        for (int p = 3; p >= 1; p--) begin
            wr(REG_CTRL, 32'(p << 4) | 32'h0000_0003);
            rd(REG_CTRL);
            `CHK("pattern", 32'(p << 4) | 32'h0000_0003, v)
        end
        line(1, 0, -1);
        wr(REG_CTRL, 32'h0000_0017);
        line(1, 1, -1);
        wr(REG_TARGET, 32'h0000_0040);
        wr(REG_CTRL, 32'h0000_0011);
        `CHK("dark en", 1'b0, dk)
        cmd(32'h0000_0001);
        `CHK("target used", 8'h40, v[15:8])
        line(1, 0, 64);
        wr(REG_CTRL, 32'h0000_0010);
        line(1, 0, -1);
        wr(REG_SLOT, 32'h0000_0001);
        cmd(32'h0000_0002);
        wr(REG_SLOT, 32'h0000_0005);
        cmd(32'h0000_0004);
        `CHK("refused", 1'b1, v[STAT_REFUSE_BIT])
        wr(REG_STATUS, 32'h0000_0004);
        rd(REG_STATUS);
        `CHK("refused clear", 1'b0, v[STAT_REFUSE_BIT])
        wr(REG_TARGET, 32'h0000_0020);
        wr(REG_CTRL, 32'h0000_0011);
        cmd(32'h0000_0001);
        line(1, 0, 32);
        wr(REG_SLOT, 32'h0000_0001);
        cmd(32'h0000_0004);
        line(1, 0, 64);
        // auto target is the peak ramp value seen while accumulating
        wr(REG_CTRL, 32'h0000_0019);
        cmd(32'h0000_0001);
        `CHK("auto target", 8'(LW - 1), v[15:8])
        line(1, 0, LW - 1);
        finish_test();
    end
endmodule
